// File: rtl/rtsio_pkg.sv
/*
 * Package of the remote test select and status port.
 * Holds the APB map, field positions, reset values and timing counts.
 * Assumes a 100 MHz core clock.
 */
package rtsio_pkg;
    // APB register byte offsets.
    localparam logic [7:0] RTSIO_CTRL_OFF = 8'h00;
    localparam logic [7:0] RTSIO_STAT_OFF = 8'h04;
    localparam logic [7:0] RTSIO_RESULT_OFF = 8'h08;
    // Control register fields.
    localparam int CTRL_REMOTE_EN_BIT = 0;
    localparam int CTRL_REMOTE_STOP_BIT = 1;
    localparam int CTRL_PANEL_STOP_BIT = 2;
    localparam int CTRL_PASS_BIT = 3;
    localparam int CTRL_FAIL_BIT = 4;
    localparam int CTRL_CAUSE_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // Fail cause codes written by software.
    localparam logic [1:0] CAUSE_UPPER = 2'h0;
    localparam logic [1:0] CAUSE_LOWER = 2'h1;
    localparam logic [1:0] CAUSE_ARC = 2'h2;
    localparam logic [1:0] CAUSE_GROUND = 2'h3;
    // Highest test numbers per mode.
    localparam logic [3:0] MAX_SINGLE = 4'hf;
    localparam logic [3:0] MAX_MULTI = 4'h9;
    // Debounce time and its cycle count.
    localparam int CLK_HZ = 100_000_000;
    localparam int DEBOUNCE_US = 10;
    localparam int DEBOUNCE_CYC = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
    // Test state machine.
    typedef enum logic [1:0] {
        RTS_IDLE = 2'b00,
        RTS_RUN = 2'b01,
        RTS_PASS = 2'b10,
        RTS_FAIL = 2'b11
    } rts_state_t;
endpackage

// File: rtl/rtsio_top.sv
/*
 * Remote parallel control and status port of a high voltage tester.
 * Assumes contact inputs arrive unsynchronised, active low closures,
 * and that software on APB reports each test's verdict and fail cause.
 */
`timescale 1ns/1ps
module rtsio_top (
    // Clock and reset.
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    // APB slave.
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Remote inputs, active low contact closures.
    input wire logic START_N_I,
    input wire logic STOP_N_I,
    input wire logic MULTI_STEP_N_I,
    input wire logic INTERLOCK_ARM_N_I,
    input wire logic INTERLOCK_LOOP_N_I,
    input wire logic [3:0] SELECT_CODE_I,
    // Contact and trip outputs, high means closed.
    output logic GOOD_RESULT_CONTACT_A_O,
    output logic GOOD_RESULT_CONTACT_B_O,
    output logic BAD_RESULT_CONTACT_A_O,
    output logic BAD_RESULT_CONTACT_B_O,
    output logic IN_PROGRESS_CONTACT_A_O,
    output logic IN_PROGRESS_CONTACT_B_O,
    output logic UPPER_LIMIT_TRIP_O,
    output logic LOWER_LIMIT_TRIP_O,
    output logic ARC_LIMIT_TRIP_O,
    output logic GROUND_CONTINUITY_TRIP_O,
    output logic HV_ENABLE_O
);
    import rtsio_pkg::*;

    localparam int NIN = 9;

    typedef struct packed {
        logic [NIN-1:0] s1;
        logic [NIN-1:0] s2;
        logic [NIN-1:0] deb;
        logic [NIN-1:0][19:0] cnt;
        logic start_prev;
        rts_state_t st;
        logic multi;
        logic [3:0] test_num;
        logic [1:0] cause;
        logic remote_en;
        logic ign_ilock;
        logic ign_stop;
        logic invalid_req;
        logic [31:0] rdata;
    } rtsio_state_t;

    rtsio_state_t r_q, r_d;
    logic [NIN-1:0] raw;
    logic start_lvl, stop_lvl, multi_lvl, arm_lvl, loop_lvl;
    logic [3:0] sel;
    logic ilock_ok, start_evt, stop_any, wr, rd;
    logic sw_rstop, sw_pstop, sw_pass, sw_fail;

    // Inputs are inverted so that a closed contact reads one.
    assign raw = {~SELECT_CODE_I, ~INTERLOCK_LOOP_N_I,
                  ~INTERLOCK_ARM_N_I, ~MULTI_STEP_N_I, ~STOP_N_I,
                  ~START_N_I};
    assign start_lvl = r_q.deb[0];
    assign stop_lvl = r_q.deb[1];
    assign multi_lvl = r_q.deb[2];
    assign arm_lvl = r_q.deb[3];
    assign loop_lvl = r_q.deb[4];
    assign sel = r_q.deb[8:5];

    // Interlock only gates when armed; then the loop must be closed.
    assign ilock_ok = !arm_lvl || loop_lvl;
    assign start_evt = start_lvl && !r_q.start_prev;
    assign wr = PSEL_I && PENABLE_I && PWRITE_I;
    assign rd = PSEL_I && !PWRITE_I;
    assign sw_rstop = wr && PADDR_I == RTSIO_CTRL_OFF
                      && PWDATA_I[CTRL_REMOTE_STOP_BIT];
    assign sw_pstop = wr && PADDR_I == RTSIO_CTRL_OFF
                      && PWDATA_I[CTRL_PANEL_STOP_BIT];
    assign sw_pass = wr && PADDR_I == RTSIO_CTRL_OFF
                     && PWDATA_I[CTRL_PASS_BIT];
    assign sw_fail = wr && PADDR_I == RTSIO_CTRL_OFF
                     && PWDATA_I[CTRL_FAIL_BIT];
    // Remote stop serves only with remote on; pin and panel otherwise.
    assign stop_any = r_q.remote_en ? sw_rstop
                                    : (stop_lvl || sw_pstop);

    // Next state: debounce, test sequencing and register access.
    always_comb begin
        r_d = r_q;
        r_d.s1 = raw;
        r_d.s2 = r_q.s1;
        for (int i = 0; i < NIN; i++) begin
            if (r_q.s2[i] == r_q.deb[i]) begin
                r_d.cnt[i] = '0;
            end else if (r_q.cnt[i] == 20'(DEBOUNCE_CYC - 1)) begin
                r_d.deb[i] = r_q.s2[i];
                r_d.cnt[i] = '0;
            end else begin
                r_d.cnt[i] = r_q.cnt[i] + 20'h1;
            end
        end
        r_d.start_prev = start_lvl;
        r_d.ign_ilock = 1'b0;
        r_d.ign_stop = 1'b0;
        r_d.invalid_req = 1'b0;
        case (r_q.st)
            RTS_IDLE, RTS_PASS: begin
                if (start_evt) begin
                    if (stop_lvl) begin
                        r_d.ign_stop = 1'b1;
                    end else if (!ilock_ok) begin
                        r_d.ign_ilock = 1'b1;
                    end else if (multi_lvl && (sel == 4'h0
                                 || sel > MAX_MULTI)) begin
                        r_d.invalid_req = 1'b1;
                    end else if (!multi_lvl && sel == 4'h0) begin
                        r_d.invalid_req = 1'b1;
                    end else begin
                        r_d.st = RTS_RUN;
                        r_d.test_num = sel;
                        r_d.multi = multi_lvl;
                    end
                end else if (r_q.st == RTS_PASS && stop_any) begin
                    r_d.st = RTS_IDLE;
                end
            end
            RTS_RUN: begin
                if (stop_lvl || stop_any || !ilock_ok) begin
                    r_d.st = RTS_IDLE;
                end else if (sw_fail) begin
                    r_d.st = RTS_FAIL;
                    r_d.cause = PWDATA_I[CTRL_CAUSE_LSB+:2];
                end else if (sw_pass) begin
                    r_d.st = RTS_PASS;
                end
            end
            RTS_FAIL: begin
                if (stop_any) begin
                    r_d.st = RTS_IDLE;
                end
            end
            default: r_d.st = RTS_IDLE;
        endcase
        if (wr && PADDR_I == RTSIO_CTRL_OFF) begin
            r_d.remote_en = PWDATA_I[CTRL_REMOTE_EN_BIT];
        end
        // Read data captured in setup so it is valid in access.
        if (rd && !PENABLE_I) begin
            case (PADDR_I)
                RTSIO_CTRL_OFF: r_d.rdata = {31'h0, r_q.remote_en};
                RTSIO_STAT_OFF: r_d.rdata = {22'h0, r_q.invalid_req,
                    r_q.ign_stop, r_q.ign_ilock, ilock_ok, stop_lvl,
                    multi_lvl, r_q.st, r_q.cause};
                RTSIO_RESULT_OFF: r_d.rdata = {27'h0, r_q.multi,
                                               r_q.test_num};
                default: r_d.rdata = 32'h0;
            endcase
        end
    end

    // State register.
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // APB answers in the access cycle, no wait states.
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && PADDR_I != RTSIO_CTRL_OFF
                       && PADDR_I != RTSIO_STAT_OFF
                       && PADDR_I != RTSIO_RESULT_OFF;
    assign PRDATA_O = r_q.rdata;

    // Contacts and trips decode straight from the state flops.
    assign GOOD_RESULT_CONTACT_A_O = r_q.st == RTS_PASS;
    assign GOOD_RESULT_CONTACT_B_O = r_q.st == RTS_PASS;
    assign BAD_RESULT_CONTACT_A_O = r_q.st == RTS_FAIL;
    assign BAD_RESULT_CONTACT_B_O = r_q.st == RTS_FAIL;
    assign IN_PROGRESS_CONTACT_A_O = r_q.st == RTS_RUN;
    assign IN_PROGRESS_CONTACT_B_O = r_q.st == RTS_RUN;
    assign HV_ENABLE_O = r_q.st == RTS_RUN;
    assign UPPER_LIMIT_TRIP_O = r_q.st == RTS_FAIL
                                && r_q.cause == CAUSE_UPPER;
    assign LOWER_LIMIT_TRIP_O = r_q.st == RTS_FAIL
                                && r_q.cause == CAUSE_LOWER;
    assign ARC_LIMIT_TRIP_O = r_q.st == RTS_FAIL
                              && r_q.cause == CAUSE_ARC;
    assign GROUND_CONTINUITY_TRIP_O = r_q.st == RTS_FAIL
                                      && r_q.cause == CAUSE_GROUND;

    // Checks on the sequencing.
    stop_aborts_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        r_q.st == RTS_RUN && stop_lvl |=> r_q.st == RTS_IDLE)
        else $error("stop did not abort test");
    fail_holds_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        r_q.st == RTS_FAIL && !stop_any |=> r_q.st == RTS_FAIL)
        else $error("fail left without stop");
    pass_holds_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        r_q.st == RTS_PASS && !start_evt && !stop_any
        |=> r_q.st == RTS_PASS)
        else $error("pass dropped early");
    run_contacts_a: assert property (@(posedge CLK_I)
        disable iff (!ARST_N_I)
        IN_PROGRESS_CONTACT_A_O == (r_q.st == RTS_RUN))
        else $error("in progress contact wrong");
    one_trip_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
        $onehot0({UPPER_LIMIT_TRIP_O, LOWER_LIMIT_TRIP_O,
        ARC_LIMIT_TRIP_O, GROUND_CONTINUITY_TRIP_O})
        && (BAD_RESULT_CONTACT_A_O == (UPPER_LIMIT_TRIP_O
        | LOWER_LIMIT_TRIP_O | ARC_LIMIT_TRIP_O
        | GROUND_CONTINUITY_TRIP_O)))
        else $error("fail cause not exactly one");
    start_latch_a: assert property (@(posedge CLK_I)
        disable iff (!ARST_N_I)
        r_q.st == RTS_IDLE && start_evt && ilock_ok && !stop_lvl
        && sel != 4'h0 && !multi_lvl
        |=> r_q.st == RTS_RUN && r_q.test_num == $past(sel))
        else $error("start not taken with select code");
    multi_zero_a: assert property (@(posedge CLK_I)
        disable iff (!ARST_N_I)
        r_q.st != RTS_RUN && start_evt && multi_lvl && sel == 4'h0
        |=> r_q.st != RTS_RUN)
        else $error("invalid multi request ran");
    ilock_block_a: assert property (@(posedge CLK_I)
        disable iff (!ARST_N_I)
        r_q.st == RTS_IDLE && start_evt && !ilock_ok
        |=> r_q.st == RTS_IDLE && r_q.ign_ilock)
        else $error("start taken without interlock");
    multi_limit_a: assert property (@(posedge CLK_I)
        disable iff (!ARST_N_I)
        r_q.st == RTS_RUN && r_q.multi |-> r_q.test_num <= MAX_MULTI)
        else $error("multi test number out of range");
    cv_pass: cover property (@(posedge CLK_I) r_q.st == RTS_PASS);
    cv_fail: cover property (@(posedge CLK_I) r_q.st == RTS_FAIL);
    cv_abort: cover property (@(posedge CLK_I)
        r_q.st == RTS_RUN ##1 r_q.st == RTS_IDLE);
    cv_ignored: cover property (@(posedge CLK_I) r_q.ign_stop);
endmodule // rtsio_top

// File: sim/rtsio_ctl_model.sv
/*
 * Model of the automation controller wired to the remote port.
 * Assumes active low contact closures and the design's input filter.
 */
`timescale 1ns/1ps
module rtsio_ctl_model #(
    parameter int SETTLE = 100010
) (
    // Clock.
    input wire logic clk_i,
    // Contact closures towards the port.
    output logic start_n_o,
    output logic stop_n_o,
    output logic multi_step_n_o,
    output logic arm_n_o,
    output logic loop_n_o,
    output logic [3:0] select_code_o
);
    // All contacts open at power up.
    initial begin
        {start_n_o, stop_n_o, multi_step_n_o, arm_n_o, loop_n_o} = 5'h1f;
        select_code_o = 4'hf;
    end
    // Waits until a contact change has passed the input filter.
    task automatic settle();
        repeat (SETTLE) @(posedge clk_i);
    endtask
    // Select code is set a full filter time before start and held after.
    task automatic start_test(input logic [3:0] code, input logic multi);
        @(posedge clk_i);
        select_code_o <= ~code;
        multi_step_n_o <= ~multi;
        settle();
        start_n_o <= 1'b0;
        settle();
        start_n_o <= 1'b1;
        settle();
    endtask
    // Closes or opens the stop contact.
    task automatic set_stop(input logic closed);
        @(posedge clk_i);
        stop_n_o <= ~closed;
        settle();
    endtask
    // Sets the interlock arm and loop contacts.
    task automatic set_lock(input logic arm, input logic loop);
        @(posedge clk_i);
        arm_n_o <= ~arm;
        loop_n_o <= ~loop;
        settle();
    endtask
endmodule // rtsio_ctl_model

// File: sim/remote_test_select_status_io_test.sv
/*
 * Self-checking bench of the remote port, with a state model.
 * Assumes the design and the controller model compiled beforehand.
 */
`timescale 1ns/1ps
module remote_test_select_status_io_test;
    import rtsio_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic start_n, stop_n, multi_n, arm_n, loop_n;
    logic [3:0] sel, code;
    logic [10:0] pins;
    int mismatches = 0, n_checks = 0, cyc = 0, st = 0, cause = 0;
    int seed = 32'h175c;
    rtsio_top dut (.CLK_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .START_N_I(start_n), .STOP_N_I(stop_n),
        .MULTI_STEP_N_I(multi_n), .INTERLOCK_ARM_N_I(arm_n),
        .INTERLOCK_LOOP_N_I(loop_n), .SELECT_CODE_I(sel),
        .GOOD_RESULT_CONTACT_A_O(pins[10]), .GOOD_RESULT_CONTACT_B_O(pins[9]),
        .BAD_RESULT_CONTACT_A_O(pins[8]), .BAD_RESULT_CONTACT_B_O(pins[7]),
        .IN_PROGRESS_CONTACT_A_O(pins[6]), .IN_PROGRESS_CONTACT_B_O(pins[5]),
        .UPPER_LIMIT_TRIP_O(pins[4]), .LOWER_LIMIT_TRIP_O(pins[3]),
        .ARC_LIMIT_TRIP_O(pins[2]), .GROUND_CONTINUITY_TRIP_O(pins[1]),
        .HV_ENABLE_O(pins[0]));
    rtsio_ctl_model #(.SETTLE(DEBOUNCE_CYC + 10)) ctl (.clk_i(clk),
        .start_n_o(start_n), .stop_n_o(stop_n), .multi_step_n_o(multi_n),
        .arm_n_o(arm_n), .loop_n_o(loop_n), .select_code_o(sel));
    // Free running clock.
    always #5 clk = ~clk;
    // Cuts a hung run short.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90_000) begin
            mismatches++;
            wrap_up();
        end
    end
    // Compares one value with its expectation.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // Compares every contact, trip and drive output with the model.
    task automatic check_pins();
        logic [10:0] e;
        @(negedge clk);
        e = {{2{st == 2}}, {2{st == 3}}, {2{st == 1}}, st == 3 && cause == 0,
            st == 3 && cause == 1, st == 3 && cause == 2,
            st == 3 && cause == 3, st == 1};
        check({21'h0, pins}, {21'h0, e});
    endtask
    // One APB transfer; read data and error are taken with pready.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        logic ok;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // Answer is taken at the rising edge that samples pready high.
        do begin
            @(posedge clk);
            ok = pready;
            rd = prdata;
            er = pslverr;
            n++;
        end while (ok !== 1'b1 && n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) mismatches++;
        repeat (2) @(posedge clk);
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Main sequence.
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        check_pins();
        apb(1'b0, RTSIO_CTRL_OFF, 32'h0);
        check(rd, CTRL_RESET);
        apb(1'b0, 8'h0c, 32'h0);
        check({31'h0, er}, 32'h1);
        code = 4'h1 + 4'($unsigned($random(seed)) % 15);
        ctl.start_test(code, 1'b0);
        st = 1;
        check_pins();
        apb(1'b0, RTSIO_RESULT_OFF, 32'h0);
        check(rd & 32'h1f, {27'h0, 1'b0, code});
        apb(1'b1, RTSIO_CTRL_OFF, 32'h1 << CTRL_PASS_BIT);
        st = 2;
        check_pins();
        ctl.start_test(MAX_MULTI, 1'b1);
        st = 1;
        check_pins();
        apb(1'b0, RTSIO_RESULT_OFF, 32'h0);
        check(rd & 32'h1f, {27'h0, 1'b1, MAX_MULTI});
        for (int i = 0; i < 4; i++) begin
            if (i != 0) ctl.start_test(4'(i), 1'b0);
            apb(1'b1, RTSIO_CTRL_OFF, (32'h1 << CTRL_FAIL_BIT) | (i << 8));
            st = 3;
            cause = i;
            check_pins();
            if (i == 0) begin
                ctl.start_test(4'h2, 1'b0);
                check_pins();
            end
            apb(1'b1, RTSIO_CTRL_OFF, 32'h1 << CTRL_PANEL_STOP_BIT);
            st = 0;
            check_pins();
        end
        ctl.start_test(4'h0, 1'b1);
        check_pins();
        ctl.start_test(4'h3, 1'b0);
        ctl.set_stop(1'b1);
        check_pins();
        ctl.set_stop(1'b0);
        ctl.set_lock(1'b1, 1'b0);
        ctl.start_test(4'h4, 1'b0);
        check_pins();
        ctl.set_lock(1'b1, 1'b1);
        ctl.start_test(4'h4, 1'b0);
        st = 1;
        check_pins();
        wrap_up();
    end
endmodule // remote_test_select_status_io_test
